// file: hdl/dbsp_pkg.sv
package dbsp_pkg;

  // ****************************************
  // Array organisation of the two variants
  // ****************************************
  localparam int LANE_W = 9;
  localparam int BURST_LEN = 4;
  localparam int NUM_ARRAYS = 4;
  localparam int BCNT_W = 2;
  localparam int X18_DATA_W = 18;
  localparam int X18_ADDR_W = 20;
  localparam int X18_ARRAY_DEPTH = 262144;
  localparam int X36_DATA_W = 36;
  localparam int X36_ADDR_W = 19;
  localparam int X36_ARRAY_DEPTH = 131072;

  // ****************************************
  // Pin bundle widths (larger of the two variants for each)
  // ****************************************
  localparam int MAX_DATA_W = 36;
  localparam int MAX_ADDR_W = 20;
  localparam int MAX_LANES = 4;
  localparam int BURST_DATA_W = BURST_LEN * MAX_DATA_W;
  localparam int BURST_BW_W = BURST_LEN * MAX_LANES;

  // ****************************************
  // Pin encodings and host spacing
  // ****************************************
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  localparam int HOST_WR_SH_W = 4;
  localparam int HOST_RD_SH_W = 6;

  typedef enum logic [2:0] {
    DBSP_IDLE = 3'b001,
    DBSP_WRITE = 3'b010,
    DBSP_READ = 3'b100
  } dbsp_state_e;

endpackage

// file: hdl/dbsp_if.sv
`timescale 1ns/1ps
interface dbsp_if;
  import dbsp_pkg::*;

  logic k;
  logic c;
  logic single_clk;
  logic load_strobe_n;
  logic rw;
  logic [MAX_ADDR_W-1:0] addr;
  logic [MAX_LANES-1:0] byte_lane_write_n;
  logic [MAX_DATA_W-1:0] dq_h;
  logic dq_h_oe;
  logic [MAX_DATA_W-1:0] dq_d;
  logic dq_d_oe;
  logic [MAX_DATA_W-1:0] dq;

  // Shared data pins; device drive wins, floating bus reads as zero
  assign dq = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : '0);

  modport dev (
    input k, c, single_clk, load_strobe_n, rw, addr, byte_lane_write_n, dq,
    output dq_d, dq_d_oe
  );

  modport host (
    output k, c, single_clk, load_strobe_n, rw, addr, byte_lane_write_n,
    output dq_h, dq_h_oe,
    input dq
  );

endinterface

// file: hdl/dbsp_device.sv
`timescale 1ns/1ps

// How it works
// RULE_01: Write words taken on K and K-bar edges
// RULE_02: Read words launched on output clock edges
// RULE_03: Data drivers released when no read
// RULE_04: Controller pulls load strobe low per transaction
// RULE_05: Every transaction moves four words
// RULE_06: Byte selects active low, sampled both edges
// RULE_07: Each select gates one nine-bit lane
// RULE_08: Selects sampled with their data beat
// RULE_09: Unselected byte keeps stored value
// RULE_10: One address bus for reads and writes
// RULE_11: Low address bits load burst counter
// RULE_12: Narrow variant: four 256K arrays, 20 bits
// RULE_13: Wide variant: four 128K arrays of 36
// RULE_14: Read/write select high reads, low writes
// RULE_15: Access starts and controls latch on K
// RULE_16: Wide variant uses 19 address bits
// RULE_17: Burst counter wraps modulo four
module dbsp_device
  import dbsp_pkg::*;
#(
  parameter bit X36 = 1'b1
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Memory pins
  dbsp_if.dev BUS,
  // Status
  output logic BUSY,
  output logic [1:0] BURST_POS
);

  // ****************************************
  // Variant geometry
  // ****************************************
  // RULE_12 narrow geometry
  // RULE_13 wide geometry
  localparam int DW = X36 ? X36_DATA_W : X18_DATA_W;
  // RULE_16 wide address span
  localparam int AW = X36 ? X36_ADDR_W : X18_ADDR_W;
  localparam int ROW_W = AW - BCNT_W;
  localparam int ROWS = X36 ? X36_ARRAY_DEPTH : X18_ARRAY_DEPTH;
  localparam int LANES = DW / LANE_W;
  localparam logic [1:0] LAST_BEAT = 2'(BURST_LEN - 1);

  logic [DW-1:0] mem [NUM_ARRAYS][ROWS];
  dbsp_state_e state_ff;
  logic [1:0] beat_ff;
  logic [BCNT_W-1:0] bcnt_ff;
  logic [ROW_W-1:0] row_ff;
  logic [DW-1:0] dout_ff;
  logic dout_oe_ff;
  logic out_lvl;
  logic write_go;
  logic read_go;
  logic last_beat;
  logic load;
  logic [MAX_LANES-1:0] lane_we;
  logic [DW-1:0] rd_word;

  // ****************************************
  // Beat timing
  // ****************************************
  // Without output clocks the input clocks time the read data.
  // RULE_02 output clock choice
  assign out_lvl = BUS.single_clk ? BUS.k : BUS.c;

  // K sampled high marks a K rising edge, low a K-bar rising edge.
  // A beat whose clock phase does not match waits for the next edge.
  always_comb begin
    write_go = 1'b0;
    read_go = 1'b0;
    case (state_ff)
      DBSP_WRITE: begin
        // RULE_01 write beat parity
        // RULE_06 selects on both edges
        write_go = (BUS.k == beat_ff[0]);
      end
      DBSP_READ: begin
        // RULE_02 read beat parity
        read_go = (out_lvl == beat_ff[0]);
      end
      default: begin
        write_go = 1'b0;
        read_go = 1'b0;
      end
    endcase
  end

  // RULE_05 four beats
  assign last_beat = (write_go || read_go) && (beat_ff == LAST_BEAT);

  // A new load may overlap only the final beat, so bursts run back to
  // back; a load in mid-burst is ignored rather than corrupting it.
  // RULE_15 load on K edge
  assign load = BUS.k && !BUS.load_strobe_n &&
                ((state_ff == DBSP_IDLE) || last_beat);

  // ****************************************
  // Control state
  // ****************************************
  // An illegal one-hot code falls back to idle rather than locking up.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_ff <= DBSP_IDLE;
    end else begin
      case (state_ff)
        DBSP_IDLE: begin
          if (load) begin
            // RULE_14 direction decode
            state_ff <= (BUS.rw == RW_READ) ? DBSP_READ : DBSP_WRITE;
          end
        end
        DBSP_WRITE, DBSP_READ: begin
          if (load) begin
            state_ff <= (BUS.rw == RW_READ) ? DBSP_READ : DBSP_WRITE;
          end else if (last_beat) begin
            state_ff <= DBSP_IDLE;
          end
        end
        default: begin
          state_ff <= DBSP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      beat_ff <= 2'h0;
    end else if (load) begin
      beat_ff <= 2'h0;
    end else if (write_go || read_go) begin
      beat_ff <= beat_ff + 2'h1;
    end
  end

  // ****************************************
  // Address and burst counter
  // ****************************************
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      bcnt_ff <= '0;
      row_ff <= '0;
    end else if (load) begin
      // RULE_10 shared address
      // RULE_11 counter start
      bcnt_ff <= BUS.addr[BCNT_W-1:0];
      row_ff <= BUS.addr[AW-1:BCNT_W];
    end else if (write_go || read_go) begin
      // RULE_17 modulo four wrap
      bcnt_ff <= bcnt_ff + 2'h1;
    end
  end

  // ****************************************
  // Array write
  // ****************************************
  // Storage has no reset; contents are undefined until written.
  // RULE_06 active-low selects
  assign lane_we = ~BUS.byte_lane_write_n;

  always_ff @(posedge CLK_SYS) begin
    if (write_go) begin
      for (int l = 0; l < LANES; l++) begin
        // RULE_07 nine-bit lanes
        // RULE_08 select with beat
        // RULE_09 masked lane kept
        if (lane_we[l]) begin
          mem[bcnt_ff][row_ff][l*LANE_W +: LANE_W] <=
            BUS.dq[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ****************************************
  // Read data path
  // ****************************************
  // RULE_13 one array per burst word
  assign rd_word = mem[bcnt_ff][row_ff];

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      dout_ff <= '0;
    end else if (read_go) begin
      dout_ff <= rd_word;
    end
  end

  // Drive only in the cycle after a launch, so the host may turn the
  // bus round one cycle after the last read word.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      dout_oe_ff <= 1'b0;
    end else begin
      // RULE_03 auto release
      dout_oe_ff <= read_go;
    end
  end

  // ****************************************
  // Pin and status outputs
  // ****************************************
  // Data holds its last word; only the enable decides who owns the bus.
  assign BUS.dq_d = MAX_DATA_W'(dout_ff);
  assign BUS.dq_d_oe = dout_oe_ff;
  assign BUSY = (state_ff != DBSP_IDLE);
  assign BURST_POS = beat_ff;

endmodule

// file: hdl/dbsp_host.sv
`timescale 1ns/1ps
module dbsp_host
  import dbsp_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Memory pins
  dbsp_if.host BUS,
  // Mode
  input wire logic SINGLE_CLK,
  // Request
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [MAX_ADDR_W-1:0] REQ_ADDR,
  input wire logic [BURST_DATA_W-1:0] REQ_WDATA,
  input wire logic [BURST_BW_W-1:0] REQ_BW_N,
  output logic REQ_READY,
  // Read answer
  output logic RD_VALID,
  output logic [BURST_DATA_W-1:0] RD_DATA
);

  logic k_ff;
  logic single_ff;
  logic ld_n_ff;
  logic rw_ff;
  logic [MAX_ADDR_W-1:0] addr_ff;
  logic [BURST_DATA_W-1:0] wbuf_ff;
  logic [BURST_BW_W-1:0] wbw_ff;
  logic [MAX_DATA_W-1:0] dq_ff;
  logic [MAX_LANES-1:0] bw_n_ff;
  logic dq_oe_ff;
  logic [HOST_WR_SH_W-1:0] wr_sh_ff;
  logic [HOST_RD_SH_W-1:0] rd_sh_ff;
  logic rd_valid_ff;
  logic [BURST_DATA_W-1:0] rdata_ff;
  logic issue;
  logic [1:0] wbeat;

  // ****************************************
  // Clock generation and issue window
  // ****************************************
  // K and C run at half the system rate; C mirrors K.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      k_ff <= 1'b0;
      single_ff <= 1'b0;
    end else begin
      k_ff <= ~k_ff;
      single_ff <= SINGLE_CLK;
    end
  end

  // Loads are spaced four edges apart; a write also waits for the
  // device to release the bus after a read.
  always_comb begin
    REQ_READY = !k_ff && (wr_sh_ff[2:0] == '0) && (rd_sh_ff[2:0] == '0);
    if (REQ_WRITE && (rd_sh_ff[4:3] != '0)) begin
      REQ_READY = 1'b0;
    end
  end
  assign issue = REQ_VALID && REQ_READY;

  // ****************************************
  // Command pins
  // ****************************************
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ld_n_ff <= 1'b1;
      rw_ff <= RW_READ;
      addr_ff <= '0;
      wbuf_ff <= '0;
      wbw_ff <= '1;
    end else begin
      // RULE_04 load per transaction
      ld_n_ff <= !issue;
      if (issue) begin
        // RULE_14 direction with load
        rw_ff <= REQ_WRITE ? RW_WRITE : RW_READ;
        addr_ff <= REQ_ADDR;
        wbuf_ff <= REQ_WDATA;
        wbw_ff <= REQ_BW_N;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wr_sh_ff <= '0;
      rd_sh_ff <= '0;
    end else begin
      wr_sh_ff <= {wr_sh_ff[HOST_WR_SH_W-2:0], issue && REQ_WRITE};
      rd_sh_ff <= {rd_sh_ff[HOST_RD_SH_W-2:0], issue && !REQ_WRITE};
    end
  end

  // ****************************************
  // Write beats
  // ****************************************
  always_comb begin
    wbeat = 2'h0;
    if (wr_sh_ff[1]) begin
      wbeat = 2'h1;
    end else if (wr_sh_ff[2]) begin
      wbeat = 2'h2;
    end else if (wr_sh_ff[3]) begin
      wbeat = 2'h3;
    end
  end

  // Data and byte selects leave together so the device samples both
  // on the same edge.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      dq_ff <= '0;
      bw_n_ff <= '1;
      dq_oe_ff <= 1'b0;
    end else begin
      dq_oe_ff <= (wr_sh_ff != '0);
      if (wr_sh_ff != '0) begin
        dq_ff <= wbuf_ff[wbeat*MAX_DATA_W +: MAX_DATA_W];
        bw_n_ff <= wbw_ff[wbeat*MAX_LANES +: MAX_LANES];
      end else begin
        bw_n_ff <= '1;
      end
    end
  end

  // ****************************************
  // Read capture
  // ****************************************
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rdata_ff <= '0;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_sh_ff[5];
      for (int b = 0; b < BURST_LEN; b++) begin
        if (rd_sh_ff[b+2]) begin
          rdata_ff[b*MAX_DATA_W +: MAX_DATA_W] <= BUS.dq;
        end
      end
    end
  end

  assign BUS.k = k_ff;
  assign BUS.c = k_ff;
  assign BUS.single_clk = single_ff;
  assign BUS.load_strobe_n = ld_n_ff;
  assign BUS.rw = rw_ff;
  assign BUS.addr = addr_ff;
  assign BUS.byte_lane_write_n = bw_n_ff;
  assign BUS.dq_h = dq_ff;
  assign BUS.dq_h_oe = dq_oe_ff;
  assign RD_VALID = rd_valid_ff;
  assign RD_DATA = rdata_ff;

endmodule

// file: verification/dbsp_chk.sv
`timescale 1ns/1ps
module dbsp_chk
  import dbsp_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Pins
  input wire logic k,
  input wire logic load_strobe_n,
  input wire logic rw,
  input wire logic [MAX_LANES-1:0] byte_lane_write_n,
  input wire logic dq_h_oe,
  input wire logic dq_d_oe
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  logic rd_ld;
  assign rd_ld = !load_strobe_n && k && rw;
  sequence s_rd_load;
    !load_strobe_n && k && rw;
  endsequence
  sequence s_wr_load;
    !load_strobe_n && k && !rw;
  endsequence
  property p_rd_beats;
    s_rd_load |-> ##2 dq_d_oe [*4];
  endproperty
  a_rd_beats: assert property (p_rd_beats)
    else $error("read burst not driven for four beats");
  property p_oe_cause;
    dq_d_oe |-> $past(rd_ld, 2) || $past(rd_ld, 3) || $past(rd_ld, 4)
      || $past(rd_ld, 5);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("data driven with no read loaded");
  property p_wr_beats;
    s_wr_load |-> ##1 (dq_h_oe && !dq_d_oe) [*4];
  endproperty
  a_wr_beats: assert property (p_wr_beats)
    else $error("write burst not four beats");
  property p_one_driver;
    !(dq_h_oe && dq_d_oe);
  endproperty
  a_one_driver: assert property (p_one_driver)
    else $error("both ends drive the data pins");
  property p_load_k;
    !load_strobe_n |-> k;
  endproperty
  a_load_k: assert property (p_load_k)
    else $error("load away from the K edge");
  property p_burst_gap;
    !load_strobe_n |=> load_strobe_n [*3];
  endproperty
  a_burst_gap: assert property (p_burst_gap)
    else $error("loads closer than one burst");
  property p_sel_idle;
    !dq_h_oe |-> &byte_lane_write_n;
  endproperty
  a_sel_idle: assert property (p_sel_idle)
    else $error("byte select active outside a write");
  property p_k_run;
    !$past(RST) |-> k != $past(k);
  endproperty
  a_k_run: assert property (p_k_run)
    else $error("input clock level stuck");
endmodule

// file: verification/dbsp_tb.sv
`timescale 1ns/1ps
module dbsp_tb;
  import dbsp_pkg::*;
  localparam logic [143:0] WD = 144'h444444444333333333222222222111111111;
  localparam logic [143:0] NW = 144'hDDDDDDDDDCCCCCCCCCBBBBBBBBBAAAAAAAAA;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic single_clk = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [MAX_ADDR_W-1:0] req_addr = '0;
  logic [BURST_DATA_W-1:0] req_wdata = '0;
  logic [BURST_BW_W-1:0] req_bw_n = '1;
  logic req_ready;
  logic rd_valid;
  logic [BURST_DATA_W-1:0] rd_data;
  logic busy;
  logic [1:0] burst_pos;
  logic [BURST_DATA_W-1:0] img;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;

  dbsp_if bus_if ();
  dbsp_device #(.X36(1'b1)) u_dbsp_device (.CLK_SYS(clk_sys), .RST(rst),
    .BUS(bus_if), .BUSY(busy), .BURST_POS(burst_pos));
  dbsp_host u_dbsp_host (.CLK_SYS(clk_sys), .RST(rst), .BUS(bus_if),
    .SINGLE_CLK(single_clk), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
    .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_BW_N(req_bw_n),
    .REQ_READY(req_ready), .RD_VALID(rd_valid), .RD_DATA(rd_data));
  dbsp_chk chk_bus (.CLK_SYS(clk_sys), .RST(rst), .k(bus_if.k),
    .load_strobe_n(bus_if.load_strobe_n), .rw(bus_if.rw),
    .byte_lane_write_n(bus_if.byte_lane_write_n),
    .dq_h_oe(bus_if.dq_h_oe), .dq_d_oe(bus_if.dq_d_oe));

  always #2.5 clk_sys = ~clk_sys;

  // ****
  // Shared tasks
  // ****
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [143:0] exp,
                       input logic [143:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request held until the ready level seen before the taking edge
  task automatic issue(input logic wr, input logic [19:0] a,
                       input logic [143:0] d, input logic [15:0] bw);
    int n;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    req_bw_n <= bw;
    n = 0;
    @(negedge clk_sys);
    while (req_ready !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    check("request taken", 144'(1), 144'(n < 40));
    @(posedge clk_sys);
    req_valid <= 1'b0;
  endtask

  task automatic rd_burst(input logic [19:0] a, input logic [143:0] exp,
                          input string what);
    int n;
    issue(1'b0, a, '0, '1);
    n = 0;
    while (rd_valid !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    // The n-th falling edge trails the (n-1)-th edge after the take
    check("read latency", 144'(6), 144'(n - 1));
    check(what, exp, rd_data);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_wrap();
    issue(1'b1, 20'h00012, WD, 16'h0000);
    img = {WD[35:0], WD[143:36]};
    img = {img[35:0], img[143:36]};
    rd_burst(20'h00010, img, "wrapped read");
    rd_burst(20'h00012, WD, "offset read");
  endtask

  task automatic t_lanes();
    for (int j = 0; j < 4; j++) begin
      img[36*j+9*j +: 9] = NW[36*j+9*j +: 9];
    end
    issue(1'b1, 20'h00010, NW, 16'h7BDE);
    rd_burst(20'h00010, img, "lane write");
  endtask

  // Address bit 19 lies beyond the wide array, so it aliases
  task automatic t_single();
    @(posedge clk_sys);
    single_clk <= 1'b1;
    rd_burst(20'h80010, img, "single clock read");
    @(posedge clk_sys);
    single_clk <= 1'b0;
  endtask

  // Status outputs followed through one write burst
  task automatic t_busy();
    issue(1'b1, 20'h00020, WD, 16'h0000);
    repeat (2) @(negedge clk_sys);
    check("busy at load", 144'(1), 144'(busy));
    check("beats at load", 144'(0), 144'(burst_pos));
    repeat (2) @(negedge clk_sys);
    check("beats mid burst", 144'(2), 144'(burst_pos));
    repeat (2) @(negedge clk_sys);
    check("busy after burst", 144'(0), 144'(busy));
    rd_burst(20'h00020, WD, "plain read");
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      give_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_wrap();
    t_lanes();
    t_single();
    t_busy();
    repeat (10) @(posedge clk_sys);
    give_verdict();
  end
endmodule
